//--- design/sfc_frontend.sv
`timescale 1ns/1ns
// Summary of operation
// RL1 - The first eight bits of every command form the opcode that selects the operation.
// RL2 - Incoming bits are sampled on serial clock rising edges and outputs change on falling edges.
// RL3 - Pages are 512 or 256 bytes, aligned to their size, fixed per variant.
// RL4 - Erase sectors are 4, 64 or 256 kilobytes depending on variant and address.
// RL5 - A write to non-volatile bits is handed on as one erase-and-restore update request.
// RL6 - Control, address and data all pass serially over four to six signals.
// RL7 - Extension commands move two or four bits per clock over bidirectional lines.
// RL8 - A command is everything while chip select is low; raising it ends the command.
// RL9 - With quad width enabled the write-protect pin serves as data line two.
// RL10 - Every byte is transferred most significant bit first on each active line.
module sfc_frontend #(
   parameter int unsigned PAGE_BYTES    = sfc_pkg::PAGE_BYTES_DEF,
   parameter int unsigned SECTOR_BYTES  = sfc_pkg::UNIFORM_64K_BYTES,
   parameter int unsigned PARAM_SECTORS = sfc_pkg::PARAM_SECTORS_DEF,
   parameter bit          PARAM_AT_TOP  = 1'b0,
   parameter int unsigned FLASH_BYTES   = sfc_pkg::FLASH_BYTES_DEF
) (
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        sck_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  io_i,
   output logic      [3:0]  io_o,
   output logic      [3:0]  io_oe_o,
   input  wire logic        quad_width_enable_bit_i,
   output logic             write_protect_n_o,
   output logic             opcode_valid_o,
   output logic      [7:0]  opcode_o,
   input  wire logic [1:0]  lane_mode_i,
   input  wire logic [2:0]  addr_bytes_i,
   input  wire logic [4:0]  dummy_cycles_i,
   input  wire logic        drive_i,
   input  wire logic        is_write_i,
   output logic             addr_valid_o,
   output logic      [31:0] addr_o,
   output logic             rx_valid_o,
   output logic      [7:0]  rx_byte_o,
   output logic             tx_load_o,
   input  wire logic [7:0]  tx_byte_i,
   output logic             frame_end_o,
   output logic             update_req_o,
   output logic      [31:0] page_base_o,
   output logic      [31:0] sector_base_o,
   output logic      [31:0] sector_bytes_o
);
   import sfc_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [3:0] lane_step(input logic [1:0] mode);
      case (mode)
         LANE_DUAL: lane_step = 4'h2;
         LANE_QUAD: lane_step = 4'h4;
         default:   lane_step = 4'h1;
      endcase
   endfunction : lane_step

   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [1:0] mode,
                                           input logic [3:0] io);
      case (mode)
         LANE_DUAL: shift_in = {sh[5:0], io[1], io[0]};
         LANE_QUAD: shift_in = {sh[3:0], io[3], io[2], io[1], io[0]};
         default:   shift_in = {sh[6:0], io[0]};
      endcase
   endfunction : shift_in

   function automatic logic in_param_region(input logic [31:0] a);
      logic [31:0] span;
      span = 32'(PARAM_SECTORS * PARAM_SECTOR_BYTES);
      if (PARAM_SECTORS == 0)
         in_param_region = 1'b0;
      else if (PARAM_AT_TOP)
         in_param_region = (a >= 32'(FLASH_BYTES) - span);
      else
         in_param_region = (a < span);
   endfunction : in_param_region

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic       sck_prev;
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pin_meta <= 6'h1F;
         pin_sync <= 6'h1F;
         sck_prev <= 1'b0;
      end else begin
         pin_meta <= {sck_i, cs_n_i, io_i};
         pin_sync <= pin_meta;
         sck_prev <= pin_sync[5];
      end
   end

   logic       sck_s;
   logic       cs_n_s;
   logic [3:0] io_s;
   logic       sck_rise;
   logic       sck_fall;
   assign sck_s    = pin_sync[5];
   assign cs_n_s   = pin_sync[4];
   assign io_s     = pin_sync[3:0];
   assign sck_rise = ~cs_n_s & sck_s & ~sck_prev;    // [RL2]
   assign sck_fall = ~cs_n_s & ~sck_s & sck_prev;    // [RL2]

   // ----------------------------------------
   // frame sequencer
   // ----------------------------------------
   sfc_state_t  state;
   logic [1:0]  cur_mode;
   logic [3:0]  bit_cnt;
   logic [3:0]  next_bit_cnt;
   logic [7:0]  rx_sh;
   logic [7:0]  next_rx_sh;
   logic        byte_done;
   logic [2:0]  addr_cnt;
   logic [4:0]  dummy_cnt;
   logic [31:0] addr_acc;
   logic        addr_seen;

   assign cur_mode     = (state == SFC_OPCODE) ? LANE_SINGLE : lane_mode_i;     // [RL7]
   assign next_bit_cnt = bit_cnt + lane_step(cur_mode);
   assign next_rx_sh   = shift_in(rx_sh, cur_mode, io_s);                         // [RL10]
   assign byte_done    = sck_rise && (state != SFC_WAIT) && (next_bit_cnt == 4'h8);

   always_ff @(posedge clock_i) begin
      if (rst_i || cs_n_s) begin
         state     <= SFC_IDLE;                                                   // [RL8]
         bit_cnt   <= 4'h0;
         rx_sh     <= 8'h00;
         addr_cnt  <= 3'h0;
         dummy_cnt <= 5'h00;
      end else begin
         if (state == SFC_IDLE)
            state <= SFC_OPCODE;
         if (sck_rise && state != SFC_WAIT && state != SFC_IDLE) begin
            rx_sh   <= next_rx_sh;
            bit_cnt <= (next_bit_cnt == 4'h8) ? 4'h0 : next_bit_cnt;
         end
         if (byte_done) begin
            case (state)
               SFC_OPCODE: begin                                                  // [RL1]
                  if (addr_bytes_i != 3'h0)
                     state <= SFC_ADDR;
                  else if (dummy_cycles_i != 5'h00)
                     state <= SFC_WAIT;
                  else
                     state <= SFC_DATA;
               end
               SFC_ADDR: begin
                  addr_cnt <= addr_cnt + 3'h1;
                  if (addr_cnt + 3'h1 == addr_bytes_i)
                     state <= (dummy_cycles_i != 5'h00) ? SFC_WAIT : SFC_DATA;
               end
               default: state <= state;
            endcase
         end
         if (sck_rise && state == SFC_WAIT) begin
            dummy_cnt <= dummy_cnt + 5'h01;
            if (dummy_cnt + 5'h01 == dummy_cycles_i)
               state <= SFC_DATA;
         end
      end
   end

   // ----------------------------------------
   // receive outputs
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         opcode_valid_o <= 1'b0;
         opcode_o       <= 8'h00;
         rx_valid_o     <= 1'b0;
         rx_byte_o      <= 8'h00;
         addr_valid_o   <= 1'b0;
         addr_acc       <= 32'h0000_0000;
         addr_o         <= 32'h0000_0000;
         addr_seen      <= 1'b0;
      end else begin
         opcode_valid_o <= byte_done && state == SFC_OPCODE;                      // [RL1]
         rx_valid_o     <= byte_done && state == SFC_DATA;
         addr_valid_o   <= byte_done && state == SFC_ADDR && addr_cnt + 3'h1 == addr_bytes_i;
         if (cs_n_s)
            addr_seen <= 1'b0;                                                    // [RL8]
         if (byte_done && state == SFC_OPCODE) begin
            opcode_o  <= next_rx_sh;
            addr_acc  <= 32'h0000_0000;
            addr_seen <= 1'b0;
         end
         if (byte_done && state == SFC_DATA)
            rx_byte_o <= next_rx_sh;
         if (byte_done && state == SFC_ADDR) begin
            addr_acc <= {addr_acc[23:0], next_rx_sh};                             // [RL10]
            if (addr_cnt + 3'h1 == addr_bytes_i) begin
               addr_o    <= {addr_acc[23:0], next_rx_sh};
               addr_seen <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // transmit path, falling edge
   // ----------------------------------------
   logic [7:0] tx_sh;
   logic [3:0] tx_cnt;
   logic [3:0] tx_step;
   logic       tx_active;
   logic       quad_live;
   logic [7:0] tx_cur;
   assign tx_step   = lane_step(lane_mode_i);
   assign tx_cur    = (tx_cnt == 4'h0) ? tx_byte_i : tx_sh;
   assign tx_active = (state == SFC_DATA) && drive_i;
   assign quad_live = quad_width_enable_bit_i && lane_mode_i == LANE_QUAD;        // [RL9]

   always_ff @(posedge clock_i) begin
      if (rst_i || cs_n_s) begin
         tx_sh     <= 8'h00;
         tx_cnt    <= 4'h0;
         tx_load_o <= 1'b0;
         io_o      <= 4'h0;
         io_oe_o   <= 4'h0;                                                       // [RL8]
      end else begin
         tx_load_o <= 1'b0;
         if (sck_fall && tx_active) begin                                         // [RL2]
            tx_load_o <= (tx_cnt == 4'h0);
            case (lane_mode_i)
               LANE_DUAL: begin
                  io_o    <= {2'b00, tx_cur[7], tx_cur[6]};                       // [RL10]
                  io_oe_o <= 4'h3;                                                // [RL7]
               end
               LANE_QUAD: begin
                  io_o    <= tx_cur[7:4];
                  io_oe_o <= quad_live ? 4'hF : 4'h3;                             // [RL9]
               end
               default: begin
                  io_o    <= {2'b00, tx_cur[7], 1'b0};                            // [RL6]
                  io_oe_o <= 4'h2;
               end
            endcase
            tx_sh  <= 8'(tx_cur << tx_step);
            tx_cnt <= (tx_cnt + tx_step == 4'h8) ? 4'h0 : tx_cnt + tx_step;
         end else if (!tx_active) begin
            io_oe_o <= 4'h0;
         end
      end
   end

   // ----------------------------------------
   // write-protect pin sharing
   // ----------------------------------------
   always_ff @(posedge clock_i) begin
      if (rst_i)
         write_protect_n_o <= 1'b1;
      else
         write_protect_n_o <= quad_width_enable_bit_i ? 1'b1 : io_s[2];            // [RL9]
   end

   // ----------------------------------------
   // frame end and update request
   // ----------------------------------------
   logic        cs_prev;
   logic [31:0] page_mask;
   assign page_mask = ~(32'(PAGE_BYTES) - 32'h1);                                 // [RL3]

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cs_prev        <= 1'b1;
         frame_end_o    <= 1'b0;
         update_req_o   <= 1'b0;
         page_base_o    <= 32'h0000_0000;
         sector_base_o  <= 32'h0000_0000;
         sector_bytes_o <= 32'h0000_0000;
      end else begin
         cs_prev      <= cs_n_s;
         frame_end_o  <= cs_n_s && !cs_prev;                                      // [RL8]
         update_req_o <= cs_n_s && !cs_prev && is_write_i && addr_seen;           // [RL5]
         if (cs_n_s && !cs_prev) begin
            page_base_o <= addr_o & page_mask;                                    // [RL3]
            if (in_param_region(addr_o)) begin                                    // [RL4]
               sector_base_o  <= addr_o & ~(32'(PARAM_SECTOR_BYTES) - 32'h1);
               sector_bytes_o <= 32'(PARAM_SECTOR_BYTES);
            end else begin
               sector_base_o  <= addr_o & ~(32'(SECTOR_BYTES) - 32'h1);
               sector_bytes_o <= 32'(SECTOR_BYTES);
            end
         end
      end
   end
endmodule : sfc_frontend

//--- design/sfc_pkg.sv
package sfc_pkg;
   // ----------------------------------------
   // command framing
   // ----------------------------------------
   localparam int unsigned OPCODE_BITS   = 8;
   localparam int unsigned BYTE_BITS     = 8;
   localparam int unsigned MAX_ADDR_BYTES = 4;
   localparam int unsigned SYNC_STAGES   = 2;

   // ----------------------------------------
   // lane modes
   // ----------------------------------------
   localparam logic [1:0] LANE_SINGLE = 2'h0;
   localparam logic [1:0] LANE_DUAL   = 2'h1;
   localparam logic [1:0] LANE_QUAD   = 2'h2;

   // ----------------------------------------
   // array geometry defaults
   // ----------------------------------------
   localparam int unsigned PAGE_BYTES_DEF    = 512;
   localparam int unsigned PAGE_BYTES_ALT    = 256;
   localparam int unsigned PARAM_SECTOR_BYTES = 4096;
   localparam int unsigned UNIFORM_64K_BYTES = 65536;
   localparam int unsigned UNIFORM_256K_BYTES = 262144;
   localparam int unsigned FLASH_BYTES_DEF   = 16777216;
   localparam int unsigned PARAM_SECTORS_DEF = 8;

   // ----------------------------------------
   // frame states, gray along the usual path
   // ----------------------------------------
   typedef enum logic [2:0] {
      SFC_IDLE   = 3'h0,
      SFC_OPCODE = 3'h1,
      SFC_ADDR   = 3'h3,
      SFC_WAIT   = 3'h2,
      SFC_DATA   = 3'h6
   } sfc_state_t;
endpackage : sfc_pkg

//--- testbench/sfc_frontend_assertions.sv
`timescale 1ns/1ns
module sfc_frontend_assertions #(
   parameter int unsigned PAGE_BYTES   = sfc_pkg::PAGE_BYTES_DEF,
   parameter int unsigned SECTOR_BYTES = sfc_pkg::UNIFORM_64K_BYTES
) (
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic        sck_i,
   input wire logic        cs_n_i,
   input wire logic        quad_width_enable_bit_i,
   input wire logic        is_write_i,
   input wire logic [3:0]  io_o,
   input wire logic [3:0]  io_oe_o,
   input wire logic        write_protect_n_o,
   input wire logic        opcode_valid_o,
   input wire logic [7:0]  opcode_o,
   input wire logic        frame_end_o,
   input wire logic        update_req_o,
   input wire logic        tx_load_o,
   input wire logic [31:0] page_base_o,
   input wire logic [31:0] sector_base_o,
   input wire logic [31:0] sector_bytes_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   a_opcode_held: assert property (!opcode_valid_o |-> $stable(opcode_o))
      else $error("opcode moved without pulse");
   a_frame_end_soon: assert property ($rose(cs_n_i) |-> ##[1:5] frame_end_o)
      else $error("no frame end after deselect");
   a_update_cause: assert property (update_req_o |-> frame_end_o && is_write_i)
      else $error("update without write frame end");
   a_page_aligned: assert property (update_req_o |-> page_base_o % PAGE_BYTES == 0)
      else $error("page base misaligned");
   a_sector_aligned: assert property (update_req_o |-> (sector_bytes_o == 4096
      || sector_bytes_o == SECTOR_BYTES) && sector_base_o % sector_bytes_o == 0)
      else $error("sector base or size wrong");
   a_idle_released: assert property (cs_n_i [*5] |-> io_oe_o == 4'h0)
      else $error("lines driven while deselected");
   a_quad_lines_off: assert property (!quad_width_enable_bit_i [*4] |-> io_oe_o[3:2] == 2'h0)
      else $error("upper lines driven without quad");
   a_wp_in_quad: assert property (quad_width_enable_bit_i [*5] |-> write_protect_n_o)
      else $error("write protect active in quad");
   a_out_on_fall: assert property ($changed(io_o) && !cs_n_i |-> !sck_i)
      else $error("output changed while clock high");
   c_update: cover property (update_req_o);
   c_tx_load: cover property (tx_load_o);
   c_opcode: cover property (opcode_valid_o);
   c_quad_drive: cover property (io_oe_o == 4'hF);
endmodule : sfc_frontend_assertions
bind sfc_frontend sfc_frontend_assertions #(.PAGE_BYTES(PAGE_BYTES),
   .SECTOR_BYTES(SECTOR_BYTES)) chk_u (.clock_i(clock_i), .rst_i(rst_i), .sck_i(sck_i),
   .cs_n_i(cs_n_i), .quad_width_enable_bit_i(quad_width_enable_bit_i), .is_write_i(is_write_i),
   .io_o(io_o), .io_oe_o(io_oe_o), .write_protect_n_o(write_protect_n_o),
   .opcode_valid_o(opcode_valid_o), .opcode_o(opcode_o), .frame_end_o(frame_end_o),
   .update_req_o(update_req_o), .tx_load_o(tx_load_o), .page_base_o(page_base_o),
   .sector_base_o(sector_base_o), .sector_bytes_o(sector_bytes_o));

//--- testbench/sfc_host_model.sv
`timescale 1ns/1ns
module sfc_host_model (
   input  wire logic       clock_i,
   input  wire logic [3:0] io_i,
   output logic            sck_o,
   output logic            cs_n_o,
   output logic      [3:0] io_o,
   output logic      [3:0] io_oe_o
);
   initial begin
      sck_o   = 1'b0;
      cs_n_o  = 1'b1;
      io_o    = 4'h0;
      io_oe_o = 4'h0;
   end
   // each clock level lasts six system cycles
   task automatic half();
      repeat (6) @(negedge clock_i);
   endtask : half
   task automatic start();
      cs_n_o = 1'b0;
      half();
   endtask : start
   task automatic stop();
      sck_o = 1'b0;
      half();
      cs_n_o  = 1'b1;
      io_oe_o = 4'h0;
      repeat (2) half();
   endtask : stop
   // w bits a clock, msb first; reads line 1 in single width, w lines otherwise
   task automatic xfer(input logic [7:0] b, input int w, input bit rd, output logic [7:0] r);
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      r = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
         sck_o   = 1'b0;
         io_oe_o = rd ? 4'h0 : m;
         io_o    = 4'(b >> (8 - w * (k + 1))) & m;
         half();
         sck_o = 1'b1;
         r     = (w == 1) ? {r[6:0], io_i[1]} : 8'((r << w) | 8'(io_i & m));
         half();
      end
   endtask : xfer
   task automatic pins(input logic [3:0] oe, input logic [3:0] v);
      io_oe_o = oe;
      io_o    = v;
   endtask : pins
endmodule : sfc_host_model

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import sfc_pkg::*;
   logic        clock_i = 1'b0, rst_i = 1'b1, quad_width_enable_bit_i = 1'b0;
   logic        drive_i = 1'b0, is_write_i = 1'b0;
   logic [1:0]  lane_mode_i = LANE_SINGLE;
   logic [2:0]  addr_bytes_i = 3'h0;
   logic [4:0]  dummy_cycles_i = 5'h00;
   logic [7:0]  tx_byte_i = 8'h00, opcode_o, rx_byte_o, op_cap, rx_cap, r;
   logic [3:0]  io, io_last = 4'h0, h_io, h_oe, d_io, d_oe;
   logic [31:0] addr_o, ad_cap, page_base_o, sector_base_o, sector_bytes_o;
   logic        write_protect_n_o, opcode_valid_o, addr_valid_o, rx_valid_o;
   logic        tx_load_o, frame_end_o, update_req_o;
   wire logic   sck_i, cs_n_i;
   int          err_total = 0, comparisons = 0, up_cnt = 0, n, fe_cnt = 0, ld_cnt = 0, nf, nl;
   always #5 clock_i = ~clock_i;
   // released lines: upper pair pulled up, lower pair toggles
   assign io = (h_oe & h_io) | (~h_oe & d_oe & d_io) | (~h_oe & ~d_oe & (4'hC | ~io_last));
   always @(posedge clock_i) begin
      io_last <= io;
      if (opcode_valid_o) op_cap <= opcode_o;
      if (addr_valid_o) ad_cap <= addr_o;
      if (rx_valid_o) rx_cap <= rx_byte_o;
      if (update_req_o) up_cnt <= up_cnt + 1;
      if (frame_end_o) fe_cnt <= fe_cnt + 1;
      if (tx_load_o) ld_cnt <= ld_cnt + 1;
   end
   sfc_frontend dut_u (.clock_i(clock_i), .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
      .io_i(io), .io_o(d_io), .io_oe_o(d_oe), .quad_width_enable_bit_i(quad_width_enable_bit_i),
      .write_protect_n_o(write_protect_n_o), .opcode_valid_o(opcode_valid_o),
      .opcode_o(opcode_o), .lane_mode_i(lane_mode_i), .addr_bytes_i(addr_bytes_i),
      .dummy_cycles_i(dummy_cycles_i), .drive_i(drive_i), .is_write_i(is_write_i),
      .addr_valid_o(addr_valid_o), .addr_o(addr_o), .rx_valid_o(rx_valid_o),
      .rx_byte_o(rx_byte_o), .tx_load_o(tx_load_o), .tx_byte_i(tx_byte_i),
      .frame_end_o(frame_end_o), .update_req_o(update_req_o), .page_base_o(page_base_o),
      .sector_base_o(sector_base_o), .sector_bytes_o(sector_bytes_o));
   sfc_host_model host_u (.clock_i(clock_i), .io_i(io), .sck_o(sck_i), .cs_n_o(cs_n_i),
      .io_o(h_io), .io_oe_o(h_oe));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   task automatic setup(input logic [1:0] lm, input logic [2:0] ab, input logic dr, wr);
      lane_mode_i  = lm;
      addr_bytes_i = ab;
      drive_i      = dr;
      is_write_i   = wr;
      dummy_cycles_i = 5'h00;
      n            = up_cnt;
      nf           = fe_cnt;
      nl           = ld_cnt;
      host_u.start();
   endtask : setup
   task automatic t_wp();
      host_u.pins(4'h4, 4'h0);
      repeat (6) @(negedge clock_i);
      check(write_protect_n_o, 1'b0);
      quad_width_enable_bit_i = 1'b1;
      repeat (6) @(negedge clock_i);
      check(write_protect_n_o, 1'b1);
      host_u.pins(4'h0, 4'h0);
      $display("write protect test done");
   endtask : t_wp
   task automatic t_write(input logic [23:0] a, input logic [31:0] pb, sb, sz);
      setup(LANE_SINGLE, 3'h3, 1'b0, 1'b1);
      host_u.xfer(8'h02, 1, 1'b0, r);
      for (int i = 2; i >= 0; i--) host_u.xfer(a[8*i +: 8], 1, 1'b0, r);
      host_u.stop();
      check(op_cap, 8'h02);
      check(ad_cap, a);
      check(up_cnt - n, 1);
      check(fe_cnt - nf, 1);
      check(page_base_o, pb);
      check(sector_base_o, sb);
      check(sector_bytes_o, sz);
      $display("write test done");
   endtask : t_write
   task automatic t_abort();
      setup(LANE_SINGLE, 3'h3, 1'b0, 1'b1);
      host_u.xfer(8'h02, 1, 1'b0, r);
      host_u.xfer(8'h12, 1, 1'b0, r);
      host_u.stop();
      check(up_cnt - n, 0);
      $display("abort test done");
   endtask : t_abort
   task automatic t_rx(input logic [1:0] lm, input int w, input logic [7:0] b);
      setup(lm, 3'h0, 1'b0, 1'b0);
      host_u.xfer(8'h3B, 1, 1'b0, r);
      host_u.xfer(b, w, 1'b0, r);
      host_u.stop();
      check(rx_cap, b);
      $display("receive test done");
   endtask : t_rx
   task automatic t_read(input logic [1:0] lm, input int w, input logic q, input logic [4:0] d,
                         input logic [7:0] b, input logic [7:0] exp);
      quad_width_enable_bit_i = q;
      tx_byte_i = b;
      setup(lm, 3'h0, 1'b1, 1'b0);
      dummy_cycles_i = d;
      host_u.xfer(8'h0B, 1, 1'b0, r);
      if (d != 5'h00)
         host_u.xfer(8'h00, 1, 1'b1, r);
      host_u.xfer(8'h00, w, 1'b1, r);
      host_u.stop();
      check(op_cap, 8'h0B);
      check(r, exp);
      check(ld_cnt - nl, 2);
      $display("read test done");
   endtask : t_read
   initial begin
      repeat (8) @(negedge clock_i);
      check({write_protect_n_o, d_oe, opcode_valid_o, update_req_o}, 32'h40);
      rst_i = 1'b0;
      repeat (4) @(negedge clock_i);
      $display("reset test done");
      t_wp();
      t_write(24'h012345, 32'h00012200, 32'h00010000, 32'h00010000);
      t_write(24'h001234, 32'h00001200, 32'h00001000, 32'h00001000);
      t_abort();
      t_rx(LANE_SINGLE, 1, 8'hA5);
      t_rx(LANE_DUAL, 2, 8'h5C);
      t_rx(LANE_QUAD, 4, 8'h3E);
      t_read(LANE_SINGLE, 1, 1'b1, 5'h08, 8'h96, 8'h96);
      t_read(LANE_DUAL, 2, 1'b1, 5'h00, 8'h4B, 8'h4B);
      t_read(LANE_QUAD, 4, 1'b1, 5'h00, 8'hC3, 8'hC3);
      // quad bit clear: lines 2 and 3 stay released and read as pulled high
      t_read(LANE_QUAD, 4, 1'b0, 5'h00, 8'h21, 8'hED);
      conclude();
   end
   initial begin
      #200000;
      err_total++;
      conclude();
   end
endmodule : tb_top
